/* design/lpsm_regs.sv */
// status, interrupt and mode register bank of the light/proximity sensor
`timescale 1ns/10ps
`default_nettype none
module lpsm_regs #(
  parameter logic [6:0] FACTORY_GREEN_GAIN = 7'h40,
  parameter logic [8:0] FACTORY_INFRARED_GAIN = 9'h100
) (
  input wire logic clock,
  input wire logic rstn,
  input wire lpsm_pkg::lpsm_req_s req,
  input wire logic first_revision,
  input wire logic ambient_valid,
  input wire logic [13:0] ambient_reading,
  input wire logic light_overflow,
  input wire logic near_valid,
  input wire logic [7:0] near_reading,
  output logic [7:0] rdata,
  output logic int_pin_out,
  output logic int_pin_oe,
  output lpsm_pkg::lpsm_run_s run,
  output lpsm_pkg::lpsm_gain_s gain
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [2:0] interrupt_flags;
  logic [5:0] main_control;
  logic [5:0] window_upper_high;
  logic [7:0] window_upper_low;
  logic [5:0] window_lower_high;
  logic [7:0] window_lower_low;
  logic [3:0] persist_counts;
  logic [0:0] near_threshold_side;
  logic [7:0] near_threshold_level;
  logic [7:0] green_gain_trim;
  logic [7:0] infrared_gain_trim;
  logic rev_one;
  logic strap_taken;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire hit_flags = req.addr == lpsm_pkg::ADDR_INTERRUPT_FLAGS;
  wire hit_ctl = req.addr == lpsm_pkg::ADDR_MAIN_CONTROL;
  wire hit_uh = req.addr == lpsm_pkg::ADDR_UPPER_HIGH;
  wire hit_ul = req.addr == lpsm_pkg::ADDR_UPPER_LOW;
  wire hit_lh = req.addr == lpsm_pkg::ADDR_LOWER_HIGH;
  wire hit_ll = req.addr == lpsm_pkg::ADDR_LOWER_LOW;
  wire hit_pst = req.addr == lpsm_pkg::ADDR_PERSIST_COUNTS;
  wire hit_side = req.addr == lpsm_pkg::ADDR_NEAR_THRESHOLD_SIDE;
  wire hit_lvl = req.addr == lpsm_pkg::ADDR_NEAR_THRESHOLD_LEVEL;
  wire hit_gt = req.addr == lpsm_pkg::ADDR_GREEN_GAIN_TRIM;
  wire hit_it = req.addr == lpsm_pkg::ADDR_INFRARED_GAIN_TRIM;

  // status is read-only; writes to it are dropped
  wire wr_ctl = req.wr && hit_ctl;
  wire status_read = req.rd && hit_flags;

  logic [7:0] read_mux;
  always_comb begin
    read_mux = 8'h00;
    if (hit_flags) begin
      read_mux = {5'h00, interrupt_flags};
    end else if (hit_ctl) begin
      read_mux = {2'b00, main_control};
    end else if (hit_uh) begin
      read_mux = {2'b00, window_upper_high};
    end else if (hit_ul) begin
      read_mux = window_upper_low;
    end else if (hit_lh) begin
      read_mux = {2'b00, window_lower_high};
    end else if (hit_ll) begin
      read_mux = window_lower_low;
    end else if (hit_pst) begin
      read_mux = {4'h0, persist_counts};
    end else if (hit_side) begin
      read_mux = {1'b0, near_threshold_side, 6'h00};
    end else if (hit_lvl) begin
      read_mux = near_threshold_level;
    end else if (hit_gt) begin
      read_mux = green_gain_trim;
    end else if (hit_it) begin
      read_mux = infrared_gain_trim;
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  function automatic lpsm_pkg::lpsm_run_s decode_mode(input logic [2:0] m);
    lpsm_pkg::lpsm_run_s r;
    r = '0;
    case (lpsm_pkg::lpsm_mode_e'(m))
      lpsm_pkg::LPSM_MODE_LIGHT_GIR: begin
        r = '{1'b1, 1'b1, 1'b0, lpsm_pkg::LPSM_SRC_G_MINUS_IR};
      end
      lpsm_pkg::LPSM_MODE_LIGHT_G: begin
        r = '{1'b1, 1'b1, 1'b0, lpsm_pkg::LPSM_SRC_GREEN};
      end
      lpsm_pkg::LPSM_MODE_LIGHT_IR: begin
        r = '{1'b1, 1'b1, 1'b0, lpsm_pkg::LPSM_SRC_INFRARED};
      end
      lpsm_pkg::LPSM_MODE_BOTH: begin
        r = '{1'b1, 1'b1, 1'b1, lpsm_pkg::LPSM_SRC_G_MINUS_IR};
      end
      lpsm_pkg::LPSM_MODE_NEAR_ONLY: begin
        r = '{1'b1, 1'b0, 1'b1, lpsm_pkg::LPSM_SRC_NONE};
      end
      // reserved codes fall back to shutdown
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  wire [2:0] mode_field =
    main_control[lpsm_pkg::CTL_MODE_MSB:lpsm_pkg::CTL_MODE_LSB];
  wire lpsm_pkg::lpsm_run_s next_run = decode_mode(mode_field);
  wire light_enable = main_control[lpsm_pkg::CTL_LIGHT_EN_POS];
  wire near_enable = main_control[lpsm_pkg::CTL_NEAR_EN_POS];
  wire trim_factory = main_control[lpsm_pkg::CTL_TRIM_SEL_POS];

  // ------------------------------------------------------------
  // gain selection
  // ------------------------------------------------------------
  wire [6:0] user_green =
    green_gain_trim[lpsm_pkg::GREEN_TRIM_MSB:lpsm_pkg::GREEN_TRIM_LSB];
  wire [8:0] user_infrared =
    {infrared_gain_trim, green_gain_trim[lpsm_pkg::IR_TRIM_LOW_POS]};
  wire lpsm_pkg::lpsm_gain_s next_gain = trim_factory ?
    lpsm_pkg::lpsm_gain_s'{FACTORY_GREEN_GAIN, FACTORY_INFRARED_GAIN} :
    lpsm_pkg::lpsm_gain_s'{user_green, user_infrared};

  // ------------------------------------------------------------
  // threshold comparison
  // ------------------------------------------------------------
  wire [13:0] window_upper = {window_upper_high, window_upper_low};
  wire [13:0] window_lower = {window_lower_high, window_lower_low};
  // readings are only compared while enabled and the channel runs
  wire light_armed = light_enable && next_run.ambient_run;
  wire near_armed = near_enable && next_run.near_run;
  wire light_outside = (ambient_reading > window_upper) ||
                       (ambient_reading < window_lower);
  wire near_above = near_threshold_side[0] ?
                    (near_reading > near_threshold_level) :
                    (near_reading < near_threshold_level);
  wire light_window_hit;
  wire near_hit;

  lpsm_persist u_light_persist (
    .clock(clock),
    .rstn(rstn),
    .sample_valid(ambient_valid),
    .outside(light_outside),
    .limit(persist_counts[lpsm_pkg::PST_LIGHT_MSB:lpsm_pkg::PST_LIGHT_LSB]),
    .hold_off(!light_armed),
    .event_hit(light_window_hit)
  );

  lpsm_persist u_near_persist (
    .clock(clock),
    .rstn(rstn),
    .sample_valid(near_valid),
    .outside(near_above),
    .limit(persist_counts[lpsm_pkg::PST_NEAR_MSB:lpsm_pkg::PST_NEAR_LSB]),
    .hold_off(!near_armed),
    .event_hit(near_hit)
  );

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  // overflow bypasses the window and persist filter
  wire light_set = light_armed &&
                   (light_window_hit || light_overflow);
  wire near_set = near_armed && near_hit;

  // the enable seen after a pending write gates the flag at once
  wire next_light_enable = wr_ctl ?
    req.wdata[lpsm_pkg::CTL_LIGHT_EN_POS] : light_enable;
  wire next_near_enable = wr_ctl ?
    req.wdata[lpsm_pkg::CTL_NEAR_EN_POS] : near_enable;

  // a set in the same cycle as the clearing read survives it
  wire keep_light = interrupt_flags[lpsm_pkg::FLAG_LIGHT_POS] &&
                    !status_read;
  wire keep_near = interrupt_flags[lpsm_pkg::FLAG_NEAR_POS] &&
                   !status_read;
  wire next_light_flag = next_light_enable &&
                         (light_set || keep_light);
  wire next_near_flag = next_near_enable &&
                        (near_set || keep_near);
  // only a read clears the power-up flag; only reset sets it
  wire next_power_flag = interrupt_flags[lpsm_pkg::FLAG_POWER_POS] &&
                         !status_read;

  wire [2:0] next_flags;
  assign next_flags[lpsm_pkg::FLAG_LIGHT_POS] = next_light_flag;
  assign next_flags[lpsm_pkg::FLAG_NEAR_POS] = next_near_flag;
  assign next_flags[lpsm_pkg::FLAG_POWER_POS] = next_power_flag;

  // ------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------
  // strap is latched once, right after reset release
  wire next_rev_one = strap_taken ? rev_one : first_revision;
  wire power_pulls = next_power_flag && !next_rev_one;
  wire next_int_oe = next_light_flag || next_near_flag ||
                     power_pulls;

  // ------------------------------------------------------------
  // flops
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rev_one <= 1'b0;
      strap_taken <= 1'b0;
    end else begin
      rev_one <= next_rev_one;
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_flags <= lpsm_pkg::RST_INTERRUPT_FLAGS;
    end else begin
      interrupt_flags <= next_flags;
    end
  end

  // every threshold and control returns to default on power-up
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      main_control <= lpsm_pkg::RST_MAIN_CONTROL;
    end else if (wr_ctl) begin
      main_control <= req.wdata[5:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      window_upper_high <= lpsm_pkg::RST_WINDOW_HIGH;
      window_upper_low <= lpsm_pkg::RST_WINDOW_LOW;
      window_lower_high <= lpsm_pkg::RST_WINDOW_HIGH;
      window_lower_low <= lpsm_pkg::RST_WINDOW_LOW;
    end else if (req.wr) begin
      if (hit_uh) begin
        window_upper_high <= req.wdata[5:0];
      end
      if (hit_ul) begin
        window_upper_low <= req.wdata;
      end
      if (hit_lh) begin
        window_lower_high <= req.wdata[5:0];
      end
      if (hit_ll) begin
        window_lower_low <= req.wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      persist_counts <= lpsm_pkg::RST_PERSIST_COUNTS;
      near_threshold_side <= lpsm_pkg::RST_NEAR_THRESHOLD_SIDE;
      near_threshold_level <= lpsm_pkg::RST_NEAR_THRESHOLD_LEVEL;
    end else if (req.wr) begin
      if (hit_pst) begin
        persist_counts <= req.wdata[3:0];
      end
      if (hit_side) begin
        near_threshold_side <= req.wdata[lpsm_pkg::SIDE_ABOVE_POS];
      end
      if (hit_lvl) begin
        near_threshold_level <= req.wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      green_gain_trim <= lpsm_pkg::RST_GREEN_GAIN_TRIM;
      infrared_gain_trim <= lpsm_pkg::RST_INFRARED_GAIN_TRIM;
    end else if (req.wr) begin
      if (hit_gt) begin
        green_gain_trim <= req.wdata;
      end
      if (hit_it) begin
        infrared_gain_trim <= req.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= read_mux;
    end
  end

  // shutdown only stops the analog side; registers stay intact
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run <= '0;
      gain <= '0;
    end else begin
      run <= next_run;
      gain <= next_gain;
    end
  end

  // the pin is never driven high; the board pull-up releases it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_pin_out <= 1'b0;
      int_pin_oe <= 1'b0;
    end else begin
      int_pin_out <= 1'b0;
      int_pin_oe <= next_int_oe;
    end
  end

endmodule
`default_nettype wire

/* design/lpsm_pkg.sv */
// constants, types and register map of the light/proximity status block
package lpsm_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'h06;
  localparam logic [7:0] ADDR_UPPER_LOW = 8'h07;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'h08;
  localparam logic [7:0] ADDR_LOWER_LOW = 8'h09;
  localparam logic [7:0] ADDR_PERSIST_COUNTS = 8'h0A;
  localparam logic [7:0] ADDR_NEAR_THRESHOLD_SIDE = 8'h0B;
  localparam logic [7:0] ADDR_NEAR_THRESHOLD_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_GREEN_GAIN_TRIM = 8'h0F;
  localparam logic [7:0] ADDR_INFRARED_GAIN_TRIM = 8'h10;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0] RST_INTERRUPT_FLAGS = 3'h4;
  localparam logic [5:0] RST_MAIN_CONTROL = 6'h24;
  localparam logic [5:0] RST_WINDOW_HIGH = 6'h00;
  localparam logic [7:0] RST_WINDOW_LOW = 8'h00;
  localparam logic [3:0] RST_PERSIST_COUNTS = 4'h0;
  localparam logic [0:0] RST_NEAR_THRESHOLD_SIDE = 1'h0;
  localparam logic [7:0] RST_NEAR_THRESHOLD_LEVEL = 8'h00;
  localparam logic [7:0] RST_GREEN_GAIN_TRIM = 8'h80;
  localparam logic [7:0] RST_INFRARED_GAIN_TRIM = 8'h80;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int FLAG_LIGHT_POS = 0;
  localparam int FLAG_NEAR_POS = 1;
  localparam int FLAG_POWER_POS = 2;
  localparam int CTL_LIGHT_EN_POS = 0;
  localparam int CTL_NEAR_EN_POS = 1;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_MODE_MSB = 4;
  localparam int CTL_TRIM_SEL_POS = 5;
  localparam int PST_LIGHT_LSB = 0;
  localparam int PST_LIGHT_MSB = 1;
  localparam int PST_NEAR_LSB = 2;
  localparam int PST_NEAR_MSB = 3;
  localparam int SIDE_ABOVE_POS = 6;
  localparam int GREEN_TRIM_LSB = 1;
  localparam int GREEN_TRIM_MSB = 7;
  localparam int IR_TRIM_LOW_POS = 0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LPSM_MODE_SHUTDOWN = 3'b000,
    LPSM_MODE_LIGHT_GIR = 3'b001,
    LPSM_MODE_LIGHT_G = 3'b010,
    LPSM_MODE_LIGHT_IR = 3'b011,
    LPSM_MODE_BOTH = 3'b100,
    LPSM_MODE_NEAR_ONLY = 3'b101,
    LPSM_MODE_RSVD6 = 3'b110,
    LPSM_MODE_RSVD7 = 3'b111
  } lpsm_mode_e;

  typedef enum logic [1:0] {
    LPSM_SRC_NONE = 2'b00,
    LPSM_SRC_G_MINUS_IR = 2'b01,
    LPSM_SRC_GREEN = 2'b10,
    LPSM_SRC_INFRARED = 2'b11
  } lpsm_source_e;

  // access strobe from the serial-bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpsm_req_s;

  // analog run controls decoded from the mode field
  typedef struct packed {
    logic analog_on;
    logic ambient_run;
    logic near_run;
    lpsm_source_e source;
  } lpsm_run_s;

  // gains handed to the channel datapath
  typedef struct packed {
    logic [6:0] green;
    logic [8:0] infrared;
  } lpsm_gain_s;

endpackage

/* design/lpsm_persist.sv */
// persist filter: counts consecutive out-of-limit samples
`timescale 1ns/10ps
`default_nettype none
module lpsm_persist (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sample_valid,
  input wire logic outside,
  input wire logic [1:0] limit,
  input wire logic hold_off,
  output logic event_hit
);
  logic [2:0] run_count;
  logic [2:0] bumped;
  logic [2:0] next_run_count;

  // saturate so a long excursion keeps firing
  assign bumped = (run_count == 3'h7) ? run_count : run_count + 3'h1;
  assign next_run_count = hold_off ? 3'h0 :
                          !sample_valid ? run_count :
                          outside ? bumped : 3'h0;
  // fires once the run is strictly longer than the persist count
  assign event_hit = !hold_off && sample_valid && outside &&
                     (bumped > {1'b0, limit});

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_count <= 3'h0;
    end else begin
      run_count <= next_run_count;
    end
  end
endmodule
`default_nettype wire

/* dv/lpsm_regs_assertions.sv */
// assertion checker for the light/proximity status block
`timescale 1ns/10ps
`default_nettype none
module lpsm_regs_assertions #(
  parameter logic [6:0] FACTORY_GREEN_GAIN = 7'h40,
  parameter logic [8:0] FACTORY_INFRARED_GAIN = 9'h100
) (
  input wire logic clock,
  input wire logic rstn,
  input wire lpsm_pkg::lpsm_req_s req,
  input wire logic first_revision,
  input wire logic ambient_valid,
  input wire logic [13:0] ambient_reading,
  input wire logic light_overflow,
  input wire logic near_valid,
  input wire logic [7:0] near_reading,
  input wire logic [7:0] rdata,
  input wire logic int_pin_out,
  input wire logic int_pin_oe,
  input wire lpsm_pkg::lpsm_run_s run,
  input wire lpsm_pkg::lpsm_gain_s gain
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  wire logic rd_flags = req.rd && req.addr == lpsm_pkg::ADDR_INTERRUPT_FLAGS;
  wire logic wr_ctl = req.wr && req.addr == lpsm_pkg::ADDR_MAIN_CONTROL;
  wire logic quiet = !ambient_valid && !near_valid && !light_overflow;
  wire logic rd_hole = req.rd && (req.addr inside {8'h02, 8'h03, 8'h04,
    8'h05, 8'h0D, 8'h0E} || req.addr > 8'h10);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_pin_never_high: assert property (
    int_pin_out == 1'b0) else $error("interrupt data not low");
  chk_power_pulls: assert property (
    $rose(rstn) && !first_revision && !req.rd |=> int_pin_oe)
    else $error("power-up flag did not pull the line");
  chk_rev1_silent: assert property (
    $rose(rstn) && first_revision |=> !int_pin_oe [*3])
    else $error("first revision pulled line from power-up flag");
  chk_status_release: assert property (
    rd_flags && quiet |=> !int_pin_oe)
    else $error("status read did not release the line");
  chk_pull_cause: assert property (
    $rose(int_pin_oe) |-> $past(ambient_valid) || $past(near_valid) ||
      $past(light_overflow) || !$past(rstn, 2))
    else $error("line pulled without a cause");
  chk_release_cause: assert property (
    $fell(int_pin_oe) |-> $past(rd_flags) || $past(wr_ctl))
    else $error("line released without read or disable");
  chk_shutdown_mode: assert property (
    wr_ctl && req.wdata[4:2] == 3'b000 |-> ##[1:2] run == '0)
    else $error("shutdown mode left a channel running");
  chk_trim_factory: assert property (
    wr_ctl && req.wdata[5] |-> ##[1:2]
      gain == {FACTORY_GREEN_GAIN, FACTORY_INFRARED_GAIN})
    else $error("factory gains not selected");
  chk_unmapped_zero: assert property (
    rd_hole |-> ##[1:2] rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind lpsm_regs lpsm_regs_assertions #(
  .FACTORY_GREEN_GAIN(FACTORY_GREEN_GAIN),
  .FACTORY_INFRARED_GAIN(FACTORY_INFRARED_GAIN)
) u_chk (.clock(clock), .rstn(rstn), .req(req),
  .first_revision(first_revision), .ambient_valid(ambient_valid),
  .ambient_reading(ambient_reading), .light_overflow(light_overflow),
  .near_valid(near_valid), .near_reading(near_reading), .rdata(rdata),
  .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .run(run),
  .gain(gain));
`default_nettype wire

/* dv/lpsm_host_model.sv */
// host side model: register accesses and pulled-up interrupt line
`timescale 1ns/10ps
`default_nettype none
module lpsm_host_model (
  input wire logic clock,
  input wire logic [7:0] rdata,
  input wire logic int_pin_out,
  input wire logic int_pin_oe,
  output var lpsm_pkg::lpsm_req_s req,
  output logic int_line
);
  // ----------------------------------------
  // board pull-up and access tasks
  // ----------------------------------------
  // released line floats up to the resistor, never to the last value
  assign int_line = int_pin_oe ? int_pin_out : 1'b1;
  initial req = '0;

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    // reserved mode codes are never sent
    if (addr == lpsm_pkg::ADDR_MAIN_CONTROL && data[4:3] == 2'b11) begin
      return;
    end
    @(negedge clock);
    req.wr = 1'b1;
    req.addr = addr;
    req.wdata = data;
    @(negedge clock);
    req.wr = 1'b0;
    req.wdata = ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    req.rd = 1'b1;
    req.addr = addr;
    @(negedge clock);
    req.rd = 1'b0;
    req.addr = ~addr;
    @(negedge clock);
    data = rdata;
  endtask
endmodule
`default_nettype wire

/* dv/lpsm_regs_bench.sv */
// self-checking bench of the light/proximity status block
`timescale 1ns/10ps
`default_nettype none
`define LPSM_CHECK(name, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got); \
    end \
  end
module lpsm_regs_bench;
  localparam logic [6:0] FG = 7'h40; // arbitrary
  localparam logic [8:0] FI = 9'h100; // arbitrary
  logic clock, rstn, first_revision, ambient_valid, light_overflow;
  logic near_valid, int_pin_out, int_pin_oe, int_line;
  logic [13:0] ambient_reading;
  logic [7:0] near_reading, rdata;
  logic [2:0] exp_run, got_run;
  logic [1:0] exp_src;
  lpsm_pkg::lpsm_req_s req;
  lpsm_pkg::lpsm_run_s run;
  lpsm_pkg::lpsm_gain_s gain;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] tab_addr [11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0C, 8'h0F, 8'h10, 8'h01};
  logic [7:0] tab_rst [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h80, 8'h80, 8'h24};
  logic [7:0] tab_msk [10] = '{8'h00, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h0F,
    8'h40, 8'hFF, 8'hFF, 8'hFF};

  lpsm_regs #(.FACTORY_GREEN_GAIN(FG), .FACTORY_INFRARED_GAIN(FI)) u_dut (
    .clock(clock), .rstn(rstn), .req(req), .first_revision(first_revision),
    .ambient_valid(ambient_valid), .ambient_reading(ambient_reading),
    .light_overflow(light_overflow), .near_valid(near_valid),
    .near_reading(near_reading), .rdata(rdata), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe), .run(run), .gain(gain));
  lpsm_host_model u_host (.clock(clock), .rdata(rdata),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .req(req),
    .int_line(int_line));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic rev);
    rstn = 1'b0;
    first_revision = rev;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
  endtask
  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    u_host.read_reg(addr, got);
    `LPSM_CHECK("register", exp, got)
  endtask
  task automatic check_line(input logic exp);
    for (int n = 0; n < 4 && int_line !== exp; n++) @(negedge clock);
    `LPSM_CHECK("interrupt line", exp, int_line)
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    u_host.write_reg(addr, data);
    repeat (2) @(negedge clock);
  endtask
  // the sample bus changes once valid drops, like a free-running ADC
  task automatic sample(input logic near, input logic [13:0] v);
    @(negedge clock);
    ambient_valid = !near;
    near_valid = near;
    ambient_reading = v;
    near_reading = v[7:0];
    @(negedge clock);
    ambient_valid = 1'b0;
    near_valid = 1'b0;
    ambient_reading = ~v;
    near_reading = ~v[7:0];
    repeat (2) @(negedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {ambient_valid, near_valid, light_overflow} = 3'b000;
    ambient_reading = 14'h0000;
    near_reading = 8'h00;
    do_reset(1'b0);
    check_line(1'b0);
    check_reg(8'h00, 8'h04);
    check_line(1'b1);
    check_reg(8'h00, 8'h00);
    for (int i = 0; i < 11; i++) check_reg(tab_addr[i], tab_rst[i]);
    for (int i = 0; i < 10; i++) begin
      u_host.write_reg(tab_addr[i], 8'hFF);
      check_reg(tab_addr[i], tab_msk[i]);
    end
    u_host.write_reg(8'h00, 8'hFF);
    check_reg(8'h00, 8'h00);
    wr(8'h0F, 8'hA5);
    wr(8'h10, 8'h3C);
    wr(8'h01, 8'h04);
    `LPSM_CHECK("user gain", {7'h52, 9'h079}, gain)
    // reserved codes 110 and 111 stay out of the sweep
    for (int m = 0; m < 6; m++) begin
      wr(8'h01, {3'b001, m[2:0], 2'b00});
      exp_run = {m != 0, m > 0 && m < 5, m > 3};
      exp_src = (m < 4) ? m[1:0] : 2'b00;
      got_run = {run.analog_on, run.ambient_run, run.near_run};
      `LPSM_CHECK("run", exp_run, got_run)
      if (m != 4) `LPSM_CHECK("source", exp_src, run.source)
    end
    `LPSM_CHECK("factory gain", {FG, FI}, gain)
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h10);
    wr(8'h0A, 8'h02);
    wr(8'h01, 8'h25);
    sample(1'b0, 14'h0200);
    sample(1'b0, 14'h0200);
    sample(1'b0, 14'h0050);
    sample(1'b0, 14'h0200);
    sample(1'b0, 14'h0200);
    check_line(1'b1);
    sample(1'b0, 14'h0005);
    check_line(1'b0);
    sample(1'b0, 14'h0050);
    check_line(1'b0);
    check_reg(8'h00, 8'h01);
    check_line(1'b1);
    wr(8'h01, 8'h24);
    light_overflow = 1'b1;
    check_line(1'b1);
    wr(8'h01, 8'h25);
    check_line(1'b0);
    wr(8'h01, 8'h24);
    check_line(1'b1);
    light_overflow = 1'b0;
    check_reg(8'h00, 8'h00);
    wr(8'h0B, 8'h40);
    wr(8'h0C, 8'h80);
    wr(8'h01, 8'h32);
    sample(1'b1, 14'h0080);
    check_line(1'b1);
    sample(1'b1, 14'h0081);
    check_line(1'b0);
    check_reg(8'h00, 8'h02);
    sample(1'b1, 14'h0090);
    wr(8'h01, 8'h30);
    check_line(1'b1);
    check_reg(8'h00, 8'h00);
    // below-level side: only readings under the level count
    wr(8'h0B, 8'h00);
    wr(8'h01, 8'h32);
    sample(1'b1, 14'h0090);
    check_line(1'b1);
    sample(1'b1, 14'h007F);
    check_line(1'b0);
    // reset lands while the line is pulled
    do_reset(1'b1);
    check_line(1'b1);
    check_reg(8'h00, 8'h04);
    check_reg(8'h09, 8'h00);
    check_reg(8'h01, 8'h24);
    end_of_test();
  end
endmodule
`default_nettype wire
